// ==== logic/panel_pkg.sv ====
// Shared constants, screen and display types, and the state record of the alarm panel.
package panel_pkg;
  // Clock rate and the timing figures that become cycle counts.
  localparam int CLK_MHZ = 100;
  localparam int HOLD_MS = 2000;
  localparam int HOLD_CYC = HOLD_MS * CLK_MHZ * 1000;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;

  // History depth and alarm code width.
  localparam int HIST_DEPTH = 6;
  localparam int CODE_W = 8;

  // Parameter numbers that this block reacts to.
  localparam logic [5:0] PNUM_CTRL_MODE = 6'h00;
  localparam logic [5:0] PNUM_HIST_CLR = 6'h10;
  localparam logic [5:0] PNUM_WR_DIS = 6'h13;
  localparam logic [5:0] PNUM_EXP_FIRST = 6'h14;

  // Parameter values that trigger an action.
  localparam logic [15:0] HIST_CLR_VAL = 16'h0001;
  localparam logic [15:0] WR_EXP_VAL = 16'h000E;

  // Alarm screen index: 0 current, 1 to 6 history, 7 parameter error.
  localparam logic [2:0] IDX_CUR = 3'h0;
  localparam logic [2:0] IDX_HIST_LAST = 3'h6;
  localparam logic [2:0] IDX_PERR = 3'h7;

  // Control modes.
  localparam logic MODE_POS = 1'h0;
  localparam logic MODE_SPD = 1'h1;

  // Button bit positions.
  localparam int BTN_MODE = 0;
  localparam int BTN_UP = 1;
  localparam int BTN_DOWN = 2;
  localparam int BTN_SET = 3;

  // Screens reached by the mode button, plus the maintenance detail screen.
  typedef enum logic [2:0] {SCR_STATUS, SCR_DIAG, SCR_ALARM, SCR_PARAM, SCR_DETAIL} screen_t;

  // What the lower two digits currently show.
  typedef enum logic [2:0] {D_BLANK, D_CODE, D_NONE, D_EMPTY, D_NOERR, D_IO} disp_kind_t;

  // One history slot.
  typedef struct packed {
    logic valid;
    logic [CODE_W-1:0] code;
  } hist_ent_t;

  // Everything the display needs in one bundle.
  typedef struct packed {
    disp_kind_t kind;
    logic [CODE_W-1:0] code;
    logic dark;
    logic dp4;
    logic [5:0] io_up;
    logic [4:0] io_lo;
  } disp_out_t;

  // Whole state of the panel.
  typedef struct packed {
    screen_t screen;
    logic [2:0] idx;
    logic alarm_act;
    logic alarm_clr_ok;
    logic [CODE_W-1:0] alarm_code;
    hist_ent_t [HIST_DEPTH-1:0] hist;
    logic ctrl_mode;
    logic mode_pend;
    logic exp_en;
    logic force_act;
    logic [4:0] dout;
    logic test_act;
    logic test_refused;
    logic param_ok;
    logic param_refused;
    logic [3:0] btn_prev;
    logic fclr_prev;
    logic [31:0] hold_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    disp_out_t disp;
  } state_t;

  // Reset state: status screen, position mode, empty history, no alarm.
  localparam state_t STATE_RST = '0;
endpackage

// ==== logic/alarm_panel.sv ====
// Front-panel alarm, parameter gate, I/O display and test-entry logic of the amplifier.
// Summary of operation
// - Lower two digits show alarm or parameter number.
// - Active alarm number flashes; else no-alarm sign.
// - Six history slots newest first; empty slots marked.
// - Any alarm forces the current-alarm screen.
// - Buttons still work; fourth decimal point flashes.
// - Power cycle, set, or fault clear in position mode clears a clearable alarm.
// - History erased only by history-clear parameter.
// - Set held two seconds opens detail screen.
// - Up and down step through history entries.
// - Parameter-error screen shows no-error or number.
// - Control mode write applies after power cycle.
// - Expansion parameters need write-disable changed first.
// - Upper segments inputs, lower segments outputs, lit on.
// - Segment meaning follows the control mode.
// - Forced outputs only while servo is off.
// - Mode button cycles to diagnostic, test from there.
`timescale 1ns/1ps
module alarm_panel #(
  parameter int HOLD_CYC = panel_pkg::HOLD_CYC,
  parameter int BLINK_CYC = panel_pkg::BLINK_CYC
) (
  // Clock, reset and clock enable.
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Panel buttons, levels: mode, up, down, set.
  input wire logic [3:0] i_btn,
  // Power-on event, one pulse per power cycle.
  input wire logic i_power_cycle,
  // Alarm source.
  input wire logic i_alarm_raise,
  input wire logic [panel_pkg::CODE_W-1:0] i_alarm_code,
  input wire logic i_alarm_clearable,
  input wire logic i_param_err,
  input wire logic [panel_pkg::CODE_W-1:0] i_param_err_num,
  // Parameter write port.
  input wire logic i_param_wr,
  input wire logic [5:0] i_param_num,
  input wire logic [15:0] i_param_val,
  // Digital inputs.
  input wire logic i_fault_clear_in,
  input wire logic i_servo_enable_in,
  input wire logic i_droop_clear_in,
  input wire logic i_fwd_start_in,
  input wire logic i_rev_start_in,
  input wire logic i_fwd_limit_in,
  input wire logic i_rev_limit_in,
  input wire logic i_estop_in,
  // Amplifier output levels before forcing: {op, zero speed, ready, alarm}.
  input wire logic i_in_position_out,
  input wire logic i_speed_reached_out,
  input wire logic [3:0] i_other_dout,
  // Forced output request.
  input wire logic i_force_on,
  input wire logic [4:0] i_force_val,
  // Display.
  output panel_pkg::disp_out_t o_disp,
  // Status.
  output logic o_alarm_active,
  output logic o_ctrl_mode,
  output logic o_test_active,
  output logic o_test_refused,
  output logic o_force_active,
  output logic [4:0] o_dout,
  output logic o_param_ok,
  output logic o_param_refused
);

  // Registered state and its next value.
  panel_pkg::state_t s;
  panel_pkg::state_t next_s;

  // Decoded events shared by the logic and the checks.
  logic [3:0] press;
  logic fclr_edge;
  logic exp_wr;
  logic hist_clr;
  logic set_clear;
  logic clr_req;
  logic [4:0] amp_dout;
  logic pin3;
  logic pin5;
  logic pin10;

  // Button presses are rising edges so a held button acts once.
  assign press = i_btn & ~s.btn_prev;
  assign fclr_edge = i_fault_clear_in & ~s.fclr_prev;
  assign exp_wr = i_param_wr && (i_param_num >= panel_pkg::PNUM_EXP_FIRST);
  // A refused expansion write never reaches the history clear.
  assign hist_clr = i_param_wr && (i_param_num == panel_pkg::PNUM_HIST_CLR)
                    && (i_param_val == panel_pkg::HIST_CLR_VAL);
  assign set_clear = (s.screen == panel_pkg::SCR_ALARM) && (s.idx == panel_pkg::IDX_CUR)
                     && press[panel_pkg::BTN_SET];
  // The fault clear pin exists only in position mode; in speed mode it starts motion.
  assign clr_req = set_clear || i_power_cycle
                   || (fclr_edge && (s.ctrl_mode == panel_pkg::MODE_POS));

  // Pin functions that depend on the active control mode.
  assign pin3 = (s.ctrl_mode == panel_pkg::MODE_POS) ? i_fault_clear_in : i_fwd_start_in;
  assign pin5 = (s.ctrl_mode == panel_pkg::MODE_POS) ? i_droop_clear_in : i_rev_start_in;
  assign pin10 = (s.ctrl_mode == panel_pkg::MODE_POS) ? i_in_position_out
                                                     : i_speed_reached_out;
  assign amp_dout = {i_other_dout[3:1], pin10, i_other_dout[0]};

  // Next-state logic: navigation, alarms, history, parameters, forcing, display.
  always_comb begin
    next_s = s;
    next_s.btn_prev = i_btn;
    next_s.fclr_prev = i_fault_clear_in;
    next_s.test_refused = 1'b0;
    next_s.param_ok = 1'b0;
    next_s.param_refused = 1'b0;
    next_s.hold_cnt = '0;

    // Free-running flash timer shared by the alarm number and the decimal point.
    if (s.blink_cnt == 32'(BLINK_CYC - 1)) begin
      next_s.blink_cnt = '0;
      next_s.blink = ~s.blink;
    end else begin
      next_s.blink_cnt = s.blink_cnt + 32'h00000001;
    end

    // Screen navigation; buttons keep working while an alarm is up.
    case (s.screen)
      panel_pkg::SCR_STATUS: begin
        if (press[panel_pkg::BTN_MODE]) begin
          next_s.screen = panel_pkg::SCR_DIAG;
        end
      end
      panel_pkg::SCR_DIAG: begin
        if (press[panel_pkg::BTN_MODE]) begin
          next_s.screen = panel_pkg::SCR_ALARM;
          next_s.idx = panel_pkg::IDX_CUR;
        end else if (press[panel_pkg::BTN_SET]) begin
          // Test entry is refused rather than queued, so a later servo-off needs a new press.
          if (i_servo_enable_in) begin
            next_s.test_refused = 1'b1;
          end else begin
            next_s.test_act = 1'b1;
          end
        end
      end
      panel_pkg::SCR_ALARM: begin
        if (press[panel_pkg::BTN_MODE]) begin
          next_s.screen = panel_pkg::SCR_PARAM;
        end else if (press[panel_pkg::BTN_UP]) begin
          next_s.idx = s.idx - 3'h1;
        end else if (press[panel_pkg::BTN_DOWN]) begin
          next_s.idx = s.idx + 3'h1;
        end else if (i_btn[panel_pkg::BTN_SET] && (s.idx != panel_pkg::IDX_CUR)
                     && (s.idx <= panel_pkg::IDX_HIST_LAST)) begin
          // Long hold on a history slot opens the maintenance screen.
          if (s.hold_cnt == 32'(HOLD_CYC - 1)) begin
            next_s.screen = panel_pkg::SCR_DETAIL;
          end else begin
            next_s.hold_cnt = s.hold_cnt + 32'h00000001;
          end
        end
      end
      panel_pkg::SCR_PARAM: begin
        if (press[panel_pkg::BTN_MODE]) begin
          next_s.screen = panel_pkg::SCR_STATUS;
        end
      end
      panel_pkg::SCR_DETAIL: begin
        if (press[panel_pkg::BTN_MODE]) begin
          next_s.screen = panel_pkg::SCR_ALARM;
        end
      end
      default: begin
        next_s.screen = panel_pkg::SCR_STATUS;
      end
    endcase

    // Clearing only drops a clearable alarm; others stay until reset unless a clearable alarm replaces them.
    if (clr_req && s.alarm_clr_ok) begin
      next_s.alarm_act = 1'b0;
    end

    // Power cycle applies the pending mode and ends any test operation.
    if (i_power_cycle) begin
      next_s.ctrl_mode = s.mode_pend;
      next_s.test_act = 1'b0;
    end

    // Parameter writes; expansion numbers need the write-disable unlock.
    if (i_param_wr) begin
      if (exp_wr && !s.exp_en) begin
        next_s.param_refused = 1'b1;
      end else begin
        next_s.param_ok = 1'b1;
        if (i_param_num == panel_pkg::PNUM_CTRL_MODE) begin
          next_s.mode_pend = i_param_val[0];
        end
        if (i_param_num == panel_pkg::PNUM_WR_DIS) begin
          next_s.exp_en = (i_param_val == panel_pkg::WR_EXP_VAL);
        end
      end
    end
    if (hist_clr) begin
      next_s.hist = '0;
    end

    // A new alarm comes last so it wins over any clear in the same cycle.
    if (i_alarm_raise) begin
      next_s.alarm_act = 1'b1;
      next_s.alarm_code = i_alarm_code;
      next_s.alarm_clr_ok = i_alarm_clearable;
      next_s.hist = {next_s.hist[panel_pkg::HIST_DEPTH-2:0], {1'b1, i_alarm_code}};
      next_s.screen = panel_pkg::SCR_ALARM;
      next_s.idx = panel_pkg::IDX_CUR;
      next_s.hold_cnt = '0;
    end

    // Forcing drops as soon as the servo is enabled.
    next_s.force_act = i_force_on && !i_servo_enable_in;
    next_s.dout = next_s.force_act ? i_force_val : amp_dout;

    // Display, built from the present state.
    next_s.disp.kind = panel_pkg::D_BLANK;
    next_s.disp.code = '0;
    next_s.disp.dark = 1'b0;
    next_s.disp.dp4 = s.alarm_act && s.blink;
    next_s.disp.io_up = {i_estop_in, i_rev_limit_in, i_fwd_limit_in, pin5,
                         i_servo_enable_in, pin3};
    next_s.disp.io_lo = s.dout;
    case (s.screen)
      panel_pkg::SCR_DIAG: begin
        next_s.disp.kind = panel_pkg::D_IO;
      end
      panel_pkg::SCR_ALARM: begin
        if (s.idx == panel_pkg::IDX_CUR) begin
          if (s.alarm_act) begin
            next_s.disp.kind = panel_pkg::D_CODE;
            next_s.disp.code = s.alarm_code;
            next_s.disp.dark = s.blink;
          end else begin
            next_s.disp.kind = panel_pkg::D_NONE;
          end
        end else if (s.idx == panel_pkg::IDX_PERR) begin
          if (i_param_err) begin
            next_s.disp.kind = panel_pkg::D_CODE;
            next_s.disp.code = i_param_err_num;
          end else begin
            next_s.disp.kind = panel_pkg::D_NOERR;
          end
        end else if (s.hist[s.idx - 3'h1].valid) begin
          next_s.disp.kind = panel_pkg::D_CODE;
          next_s.disp.code = s.hist[s.idx - 3'h1].code;
        end else begin
          next_s.disp.kind = panel_pkg::D_EMPTY;
        end
      end
      panel_pkg::SCR_DETAIL: begin
        next_s.disp.kind = panel_pkg::D_CODE;
        next_s.disp.code = s.hist[s.idx - 3'h1].code;
      end
      default: begin
        next_s.disp.kind = panel_pkg::D_BLANK;
      end
    endcase
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s <= panel_pkg::STATE_RST;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign o_disp = s.disp;
  assign o_alarm_active = s.alarm_act;
  assign o_ctrl_mode = s.ctrl_mode;
  assign o_test_active = s.test_act;
  assign o_test_refused = s.test_refused;
  assign o_force_active = s.force_act;
  assign o_dout = s.dout;
  assign o_param_ok = s.param_ok;
  assign o_param_refused = s.param_refused;

  // Checks run only in cycles where the state may move.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst || !i_ce);

  // A raised alarm takes over the screen at the current slot.
  alarm_screen_a: assert property (i_alarm_raise |=>
    (s.screen == panel_pkg::SCR_ALARM) && (s.idx == panel_pkg::IDX_CUR))
    else $error("alarm did not switch to current-alarm screen");
  // The new code lands in the newest slot.
  hist_push_a: assert property (i_alarm_raise |=>
    s.hist[0].valid && (s.hist[0].code == $past(i_alarm_code)))
    else $error("new alarm missing from newest history slot");
  // Older entries move down by one.
  hist_shift_a: assert property ((i_alarm_raise && !hist_clr) |=>
    (s.hist[1] == $past(s.hist[0])) && (s.hist[5] == $past(s.hist[4])))
    else $error("history did not shift down by one");
  // History changes only on a raise or on the history-clear write.
  hist_keep_a: assert property (!i_alarm_raise && !hist_clr |=> $stable(s.hist))
    else $error("history changed without raise or clear");
  // An enabled servo always cancels forcing, and outputs follow the amplifier.
  force_gate_a: assert property (i_servo_enable_in |=>
    !s.force_act && (s.dout == $past(amp_dout)))
    else $error("forced output while servo enabled");
  // Test entry with the servo on is refused and test stays idle.
  test_refuse_a: assert property ((s.screen == panel_pkg::SCR_DIAG)
    && !press[panel_pkg::BTN_MODE] && press[panel_pkg::BTN_SET] && i_servo_enable_in
    && !s.test_act |=> s.test_refused && !s.test_act)
    else $error("test entry not refused with servo on");
  // A mode write without power cycle leaves the active mode alone.
  mode_defer_a: assert property ((i_param_wr && !i_power_cycle) |=>
    s.ctrl_mode == $past(s.ctrl_mode))
    else $error("control mode changed before power cycle");
  // Locked expansion writes are refused.
  exp_guard_a: assert property ((exp_wr && !s.exp_en) |=>
    s.param_refused && !s.param_ok)
    else $error("locked expansion write accepted");
  // The servo enable segment mirrors its input one cycle later.
  io_mirror_a: assert property (1'b1 |=> s.disp.io_up[1] == $past(i_servo_enable_in))
    else $error("servo enable segment wrong");
  // With no alarm the current screen shows the no-alarm sign and no flashing point.
  no_alarm_a: assert property (((s.screen == panel_pkg::SCR_ALARM)
    && (s.idx == panel_pkg::IDX_CUR) && !s.alarm_act) |=>
    (s.disp.kind == panel_pkg::D_NONE) && !s.disp.dp4)
    else $error("no-alarm screen wrong");
  // A clearable alarm is gone after a power cycle unless a new one arrives.
  clear_power_a: assert property ((i_power_cycle && s.alarm_clr_ok && !i_alarm_raise)
    |=> !s.alarm_act)
    else $error("clearable alarm survived power cycle");

  // Main scenarios.
  raise_c: cover property (i_alarm_raise ##1 s.alarm_act);
  set_clear_c: cover property (set_clear && s.alarm_clr_ok ##1 !s.alarm_act);
  detail_c: cover property (s.screen == panel_pkg::SCR_DETAIL);
  test_c: cover property ($rose(s.test_act));
  force_c: cover property (s.force_act);
endmodule

// ==== tb/panel_model.sv ====
// Behavioural model of the operator at the panel buttons.
`timescale 1ns/1ps
module panel_model (
  // Clock that the operator acts against.
  input wire logic i_clk,
  // Button levels: mode, up, down, set; high while pressed.
  output logic [3:0] o_btn
);
  // No button is down at power-up.
  initial o_btn = 4'h0;
  // Press one button over n edges, so a long hold is as easy as a tap.
  // Changes land just after an edge, never racing the sampling edge.
  task automatic press(input int b, input int n);
    @(posedge i_clk);
    #1 o_btn[b] = 1'b1;
    repeat (n) @(posedge i_clk);
    #1 o_btn[b] = 1'b0;
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the alarm panel: parameters, I/O display, tests and alarms.
`timescale 1ns/1ps
module tb;
  // Short hold and flash counts keep the run brief.
  localparam int HOLD = 20;
  localparam int BLINK = 4;
  // Design inputs, each given a value at time zero.
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic ce = 1'b1;
  logic pc = 1'b0;
  logic ar = 1'b0;
  logic acl = 1'b0;
  logic perr = 1'b0;
  logic pwr = 1'b0;
  logic fon = 1'b0;
  logic [7:0] acode = 8'h00;
  logic [7:0] penum = 8'h00;
  logic [5:0] pnum = 6'h00;
  logic [15:0] pval = 16'h0000;
  logic [4:0] fval = 5'h00;
  // Inputs {estop, rev_limit, fwd_limit, rev_start, fwd_start, droop, servo, fault}.
  logic [7:0] din = 8'h00;
  // Amplifier outputs {op, zero speed, ready, alarm, speed reached, in position}.
  logic [5:0] amp = 6'h00;
  // Design outputs and the button levels of the operator model.
  logic [3:0] btn;
  panel_pkg::disp_out_t disp;
  logic act, mode, tact, tref, fact, pok, pref;
  logic [4:0] dout;
  // Scores, seed and the expected history, newest first.
  int n_errors = 0;
  int checked = 0;
  int n_ref = 0;
  integer seed = 32'h9851;
  logic [7:0] hq[$];
  // Parameter write table: number, value, accepted.
  logic [5:0] wn[7] = '{6'h14, 6'h13, 6'h14, 6'h13, 6'h3F, 6'h13, 6'h15};
  logic [15:0] wv[7] = '{16'h0, 16'h5, 16'h0, 16'h000E, 16'h1234, 16'h0, 16'h0};
  logic wo[7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  panel_model i_pm (.i_clk(i_clk), .o_btn(btn));
  alarm_panel #(.HOLD_CYC(HOLD), .BLINK_CYC(BLINK)) i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_btn(btn), .i_power_cycle(pc),
    .i_alarm_raise(ar), .i_alarm_code(acode), .i_alarm_clearable(acl),
    .i_param_err(perr), .i_param_err_num(penum), .i_param_wr(pwr), .i_param_num(pnum),
    .i_param_val(pval), .i_fault_clear_in(din[0]), .i_servo_enable_in(din[1]),
    .i_droop_clear_in(din[2]), .i_fwd_start_in(din[3]), .i_rev_start_in(din[4]),
    .i_fwd_limit_in(din[5]), .i_rev_limit_in(din[6]), .i_estop_in(din[7]),
    .i_in_position_out(amp[0]), .i_speed_reached_out(amp[1]), .i_other_dout(amp[5:2]),
    .i_force_on(fon), .i_force_val(fval), .o_disp(disp), .o_alarm_active(act),
    .o_ctrl_mode(mode), .o_test_active(tact), .o_test_refused(tref),
    .o_force_active(fact), .o_dout(dout), .o_param_ok(pok), .o_param_refused(pref));

  // Free-running 100 MHz clock.
  initial forever #5 i_clk = ~i_clk;
  // Refusal pulses last one cycle, so they are counted rather than sampled.
  always @(posedge i_clk) if (tref === 1'b1) n_ref <= n_ref + 1;
  // A hang counts as a mismatch and ends the run in the usual place.
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end

  // Expected upper segments; pins 3 and 5 change meaning with the mode.
  function automatic logic [5:0] exp_up(input logic m);
    return {din[7:5], m ? din[4] : din[2], din[1], m ? din[3] : din[0]};
  endfunction
  // Expected outputs; forcing only holds while the servo is off.
  function automatic logic [4:0] exp_dout(input logic m);
    if (fon && !din[1]) return fval;
    return {amp[5:3], m ? amp[1] : amp[0], amp[2]};
  endfunction

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // One tap, then time for the screen and the display register to follow.
  task automatic tap(input int b);
    i_pm.press(b, 1);
    cyc(3);
  endtask
  task automatic scr(input logic [2:0] k, input logic [7:0] c, input bit hc);
    chk("display kind", 24'(k), 24'(disp.kind));
    if (hc) chk("display code", 24'(c), 24'(disp.code));
  endtask
  // Write strobe is left high so writes may follow back to back.
  task automatic pw(input logic [5:0] n, input logic [15:0] v, input logic ok);
    pnum = n;
    pval = v;
    pwr = 1'b1;
    cyc(1);
    chk("param_ok", 24'(ok), 24'(pok));
    chk("param_refused", 24'(!ok), 24'(pref));
  endtask
  task automatic pend();
    pwr = 1'b0;
    cyc(1);
  endtask
  task automatic pcyc();
    pc = 1'b1;
    cyc(1);
    pc = 1'b0;
    cyc(2);
  endtask
  // Raise strobe is also left high for back-to-back alarms.
  task automatic raise(input logic [7:0] c, input logic cl);
    acode = c;
    acl = cl;
    ar = 1'b1;
    cyc(1);
    hq.push_front(c);
    if (hq.size() > 6) hq.pop_back();
    chk("alarm_active", 24'h1, 24'(act));
  endtask
  // From the current alarm, step down through six slots and the error screen.
  task automatic walk();
    for (int k = 1; k <= 6; k++) begin
      tap(2);
      if (k <= hq.size()) scr(panel_pkg::D_CODE, hq[k-1], 1);
      else scr(panel_pkg::D_EMPTY, 8'h00, 0);
    end
    tap(2);
    if (perr) scr(panel_pkg::D_CODE, penum, 1);
    else scr(panel_pkg::D_NOERR, 8'h00, 0);
    tap(2);
  endtask
  // Both flash phases must show within two blink periods.
  task automatic flash(input bit dk);
    int d;
    int p;
    d = 0;
    p = 0;
    for (int i = 0; i < 2 * BLINK + 4; i++) begin
      cyc(1);
      d += int'(disp.dark === 1'b1);
      p += int'(disp.dp4 === 1'b1);
    end
    chk("dp4 flashing", 24'h1, 24'(p > 0 && p < 2 * BLINK + 4));
    if (dk) chk("digits flashing", 24'h1, 24'(d > 0 && d < 2 * BLINK + 4));
  endtask
  // Reach the I/O display, then random inputs, outputs and forcing.
  task automatic io_run(input logic m);
    for (int k = 0; k < 5 && disp.kind !== panel_pkg::D_IO; k++) tap(0);
    scr(panel_pkg::D_IO, 8'h00, 0);
    repeat (8) begin
      din = 8'($random(seed));
      amp = 6'($random(seed));
      fon = 1'($random(seed));
      fval = 5'($random(seed));
      cyc(3);
      chk("io_up", 24'(exp_up(m)), 24'(disp.io_up));
      chk("dout", 24'(exp_dout(m)), 24'(dout));
      chk("io_lo", 24'(exp_dout(m)), 24'(disp.io_lo));
      chk("force_active", 24'(fon && !din[1]), 24'(fact));
    end
    din = 8'h00;
    fon = 1'b0;
    cyc(2);
  endtask

  // Main sequence.
  initial begin
    cyc(5);
    i_srst = 1'b0;
    cyc(1);
    chk("display at reset", 24'h0, 24'(disp));
    chk("mode at reset", 24'h0, 24'({act, mode, tact, fact, dout}));
    for (int i = 0; i < 7; i++) pw(wn[i], wv[i], wo[i]);
    pend();
    io_run(1'b0);
    din[1] = 1'b1;
    tap(3);
    chk("test refusals", 24'h1, 24'(n_ref));
    chk("test_active", 24'h0, 24'(tact));
    din[1] = 1'b0;
    tap(3);
    chk("test_active", 24'h1, 24'(tact));
    pw(6'h00, 16'h0001, 1'b1);
    pend();
    cyc(2);
    chk("ctrl_mode before cycle", 24'h0, 24'(mode));
    pcyc();
    chk("ctrl_mode after cycle", 24'h1, 24'(mode));
    chk("test_active", 24'h0, 24'(tact));
    io_run(1'b1);
    pw(6'h00, 16'h0000, 1'b1);
    pend();
    pcyc();
    chk("ctrl_mode", 24'h0, 24'(mode));
    tap(0);
    scr(panel_pkg::D_NONE, 8'h00, 0);
    walk();
    perr = 1'b1;
    penum = 8'($random(seed));
    tap(1);
    scr(panel_pkg::D_CODE, penum, 1);
    tap(2);
    tap(0);
    for (int i = 0; i < 7; i++) raise(8'($random(seed)), 1'b1);
    ar = 1'b0;
    cyc(2);
    scr(panel_pkg::D_CODE, hq[0], 1);
    flash(1'b1);
    walk();
    tap(1);
    tap(1);
    scr(panel_pkg::D_CODE, hq[5], 1);
    tap(2);
    tap(2);
    tap(0);
    chk("kind off alarm screen", 24'h0, 24'(disp.kind === panel_pkg::D_CODE));
    flash(1'b0);
    repeat (3) tap(0);
    tap(3);
    chk("alarm_active", 24'h0, 24'(act));
    scr(panel_pkg::D_NONE, 8'h00, 0);
    raise(8'($random(seed)), 1'b0);
    ar = 1'b0;
    cyc(1);
    tap(3);
    din[0] = 1'b1;
    cyc(2);
    din[0] = 1'b0;
    chk("unclearable alarm", 24'h1, 24'(act));
    // A power cycle drops only clearable alarms, so this one must survive it.
    pcyc();
    chk("unclearable after cycle", 24'h1, 24'(act));
    raise(8'($random(seed)), 1'b1);
    ar = 1'b0;
    pcyc();
    chk("alarm_active", 24'h0, 24'(act));
    raise(8'($random(seed)), 1'b1);
    ar = 1'b0;
    din[0] = 1'b1;
    cyc(2);
    din[0] = 1'b0;
    chk("alarm_active", 24'h0, 24'(act));
    walk();
    tap(2);
    i_pm.press(3, HOLD + 5);
    cyc(3);
    // Leaving the detail screen returns to the same slot; without it the panel goes on.
    tap(0);
    scr(panel_pkg::D_CODE, hq[0], 1);
    tap(1);
    pw(6'h10, 16'h0002, 1'b1);
    pend();
    walk();
    pw(6'h10, 16'h0001, 1'b1);
    pend();
    hq.delete();
    walk();
    // With the clock enable low a mode press must leave the screen untouched.
    ce = 1'b0;
    tap(0);
    ce = 1'b1;
    cyc(2);
    scr(panel_pkg::D_NONE, 8'h00, 0);
    print_verdict();
  end
endmodule
